// ---- hdl/wdkg_watchdog.sv ----
// Key-guarded watchdog timer with APB registers and interrupt
`timescale 1ns/1ns
`include "wdkg_regs.svh"

module wdkg_watchdog #(
  parameter int CNT_W = 18,
  parameter int SRESET_CYC = `WDKG_SRESET_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic slow_osc_clk,
  input wire logic cfg_always_on,
  input wire logic clear_watchdog_instruction_instr,
  input wire logic halt_instr,
  input wire logic halted,
  output logic device_reset,
  output logic pc_sp_reset,
  output logic irq
);

  // Period code to cycle count of the slow oscillator
  function automatic logic [CNT_W:0] period_len(input logic [2:0] sel);
    logic [4:0] e;
    e = 5'(`WDKG_EXP0);
    unique case (sel)
      3'h0: e = 5'(`WDKG_EXP0);
      3'h1: e = 5'(`WDKG_EXP1);
      3'h2: e = 5'(`WDKG_EXP2);
      3'h3: e = 5'(`WDKG_EXP3);
      3'h4: e = 5'(`WDKG_EXP4);
      3'h5: e = 5'(`WDKG_EXP5);
      3'h6: e = 5'(`WDKG_EXP6);
      3'h7: e = 5'(`WDKG_EXP7);
    endcase
    return (CNT_W + 1)'(1) << e;
  endfunction : period_len

  // Registers
  logic [7:0] ctrl_reg; // Key field and period code
  logic key_flag_reg; // Invalid-key reset cause
  logic to_reg; // Time-out status
  logic pdf_reg; // Power-down status
  logic [1:0] irq_stat_reg; // Sticky events
  logic [1:0] irq_mask_reg; // Event enables
  logic [CNT_W-1:0] cnt_reg; // Watchdog count
  logic [15:0] dly_reg; // Software reset delay
  wdkg_pkg::wdkg_key_state_t kst_reg;
  logic osc_s1_reg, osc_s2_reg, osc_s3_reg; // Oscillator sync
  logic cfg_s1_reg, cfg_s2_reg; // Option pin sync

  // Decoded conditions
  logic [4:0] key;
  logic key_a, key_b, key_bad, wdt_en, osc_tick;
  logic ovf, key_fire, wr_done, rd_done;
  logic [31:0] rd_val;
  logic rd_hit;

  assign key = ctrl_reg[`WDKG_KEY_HI:`WDKG_KEY_LO];
  assign key_a = (key == `WDKG_KEY_A);
  assign key_b = (key == `WDKG_KEY_B);
  assign key_bad = !key_a && !key_b;
  // Always-on runs on either key; register mode only on the enable key
  assign wdt_en = cfg_s2_reg ? !key_bad : key_b;
  // One tick per rising oscillator edge, from synchronised copies
  assign osc_tick = osc_s2_reg && !osc_s3_reg;
  // Last count of the selected period reached on a tick
  assign ovf = wdt_en && osc_tick &&
    ((CNT_W + 1)'(cnt_reg) ==
     period_len(ctrl_reg[`WDKG_SEL_HI:`WDKG_SEL_LO]) - 1'b1);
  // Delay expired while waiting on a bad key
  assign key_fire = (kst_reg == wdkg_pkg::WDKG_KS_WAIT) &&
    (dly_reg == 16'(SRESET_CYC - 1));
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_done = psel && penable && pready && !pwrite;

  // Synchronisers for the oscillator and option pin
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1_reg <= 1'b0;
      osc_s2_reg <= 1'b0;
      osc_s3_reg <= 1'b0;
      cfg_s1_reg <= 1'b0;
      cfg_s2_reg <= 1'b0;
    end else begin
      osc_s1_reg <= slow_osc_clk;
      osc_s2_reg <= osc_s1_reg;
      osc_s3_reg <= osc_s2_reg;
      cfg_s1_reg <= cfg_always_on;
      cfg_s2_reg <= cfg_s1_reg;
    end
  end

  // Control register: software writes, back to reset value on key reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `WDKG_CTRL_RST;
    end else if (key_fire) begin
      ctrl_reg <= `WDKG_CTRL_RST;
    end else if (wr_done && paddr == `WDKG_CTRL_OFS) begin
      ctrl_reg <= pwdata[7:0];
    end
  end

  // Key guard: a bad key waits out the delay, then resets
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      kst_reg <= wdkg_pkg::WDKG_KS_OK;
      dly_reg <= 16'h0000;
    end else begin
      unique case (kst_reg)
        wdkg_pkg::WDKG_KS_OK: begin
          dly_reg <= 16'h0000;
          // Any code other than the two keys starts the delay
          if (key_bad) begin
            kst_reg <= wdkg_pkg::WDKG_KS_WAIT;
          end
        end
        wdkg_pkg::WDKG_KS_WAIT: begin
          if (key_fire) begin
            kst_reg <= wdkg_pkg::WDKG_KS_OK;
            dly_reg <= 16'h0000;
          end else begin
            dly_reg <= dly_reg + 16'h0001;
          end
        end
      endcase
    end
  end

  // Watchdog count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (key_fire || clear_watchdog_instruction_instr || halt_instr || ovf) begin
      cnt_reg <= '0;
    end else if (wdt_en && osc_tick) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // A key reset empties the count on the next edge
  a_key_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    key_fire |=> cnt_reg == '0)
    else $error("key reset kept count");

  // The clear instruction empties the count on the next edge
  a_clr_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    clear_watchdog_instruction_instr |=> cnt_reg == '0)
    else $error("clear kept count");

  // Between oscillator ticks the count never moves on its own
  a_count_tick_only: assert property (
    @(posedge pclk) disable iff (!presetn)
    !osc_tick && !key_fire && !clear_watchdog_instruction_instr && !halt_instr
      |=> $stable(cnt_reg))
    else $error("count moved off tick");

  // Always-on option keeps counting with the stop key as well
  a_always_on_runs: assert property (
    @(posedge pclk) disable iff (!presetn)
    cfg_s2_reg && key_a && osc_tick && !ovf && !key_fire &&
      !clear_watchdog_instruction_instr && !halt_instr |=> cnt_reg == $past(cnt_reg) + 1'b1)
    else $error("always-on count stalled");

  // Key reset cause flag: hardware sets, written zero clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_flag_reg <= 1'b0;
    end else if (key_fire) begin
      key_flag_reg <= 1'b1;
    end else if (wr_done && paddr == `WDKG_CAUSE_OFS &&
                 !pwdata[`WDKG_KEYF_BIT]) begin
      key_flag_reg <= 1'b0;
    end
  end

  // A written zero clears the flag unless a key reset lands with it
  a_flag_sw_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_done && paddr == `WDKG_CAUSE_OFS && !pwdata[`WDKG_KEYF_BIT] &&
      !key_fire |=> !key_flag_reg)
    else $error("key flag not cleared");

  // Time-out and power-down status
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      to_reg <= 1'b0;
      pdf_reg <= 1'b0;
    end else begin
      // Overflow sets time-out; halt and clear instructions clear it
      if (ovf) begin
        to_reg <= 1'b1;
      end else if (halt_instr || clear_watchdog_instruction_instr) begin
        to_reg <= 1'b0;
      end
      // Halt sets power-down; clear instruction drops it
      if (halt_instr) begin
        pdf_reg <= 1'b1;
      end else if (clear_watchdog_instruction_instr) begin
        pdf_reg <= 1'b0;
      end
    end
  end

  // Clear instruction drops power-down unless a halt comes with it
  a_pdf_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    clear_watchdog_instruction_instr && !halt_instr |=> !pdf_reg)
    else $error("power-down not cleared");

  // Reset outputs: key reset gives full reset; overflow gives full reset when running, PC/SP reset when halted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_reset <= 1'b0;
      pc_sp_reset <= 1'b0;
    end else begin
      device_reset <= key_fire || (ovf && !halted);
      pc_sp_reset <= ovf && halted;
    end
  end

  // Interrupt status, mask and output; a read clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_reg <= 2'b00;
      irq_mask_reg <= 2'b00;
      irq <= 1'b0;
    end else begin
      if (rd_done && paddr == `WDKG_IRQ_OFS) begin
        // Clear only what the reader was shown; later events stay
        irq_stat_reg <= (irq_stat_reg & ~prdata[1:0]) | {key_fire, ovf};
      end else begin
        irq_stat_reg <= irq_stat_reg | {key_fire, ovf};
      end
      if (wr_done && paddr == `WDKG_MASK_OFS) begin
        irq_mask_reg <= pwdata[1:0];
      end
      irq <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Read mux
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (paddr)
      `WDKG_CTRL_OFS: rd_val[7:0] = ctrl_reg;
      `WDKG_CAUSE_OFS: rd_val[`WDKG_KEYF_BIT] = key_flag_reg;
      `WDKG_STAT_OFS: begin
        rd_val[`WDKG_TO_BIT] = to_reg;
        rd_val[`WDKG_PDF_BIT] = pdf_reg;
      end
      `WDKG_IRQ_OFS: rd_val[1:0] = irq_stat_reg;
      `WDKG_MASK_OFS: rd_val[1:0] = irq_mask_reg;
      default: rd_hit = 1'b0;
    endcase
  end

  // APB answer: one wait state, data and error captured with pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= !rd_hit;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Checks

  sequence s_halt_pulse;
    halt_instr;
  endsequence

  sequence s_cleared_after;
    ##1 (cnt_reg == '0);
  endsequence

  a_key_reset_delay: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(kst_reg == wdkg_pkg::WDKG_KS_WAIT) |->
      ##(SRESET_CYC) device_reset)
    else $error("key reset not after delay");

  a_key_flag_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    key_fire |=> key_flag_reg)
    else $error("key flag not set");

  a_key_flag_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    key_flag_reg && !(wr_done && paddr == `WDKG_CAUSE_OFS)
      |=> key_flag_reg)
    else $error("key flag lost without write");

  a_halt_clears: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_halt_pulse |-> s_cleared_after)
    else $error("halt did not clear count");

  a_pdf_halt: assert property (
    @(posedge pclk) disable iff (!presetn)
    halt_instr |=> pdf_reg && !to_reg)
    else $error("halt flags wrong");

  a_ovf_full: assert property (
    @(posedge pclk) disable iff (!presetn)
    ovf && !halted |=> device_reset && to_reg && !pc_sp_reset)
    else $error("running overflow wrong");

  a_ovf_halted: assert property (
    @(posedge pclk) disable iff (!presetn)
    ovf && halted |=> pc_sp_reset && to_reg && !device_reset)
    else $error("halted overflow wrong");

  a_stopped_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !cfg_s2_reg && key_a && !clear_watchdog_instruction_instr && !halt_instr
      |=> $stable(cnt_reg))
    else $error("disabled count moved");

  a_key_poweron: assert property (
    @(posedge pclk)
    $rose(presetn) |-> ctrl_reg[`WDKG_KEY_HI:`WDKG_KEY_LO] == `WDKG_KEY_B)
    else $error("key not loaded at reset");

  a_good_key_quiet: assert property (
    @(posedge pclk) disable iff (!presetn)
    (kst_reg == wdkg_pkg::WDKG_KS_OK) && !key_bad
      |=> kst_reg == wdkg_pkg::WDKG_KS_OK)
    else $error("valid key started reset");

endmodule : wdkg_watchdog

// ---- inc/wdkg_pkg.sv ----
// Types for the key-guarded watchdog
package wdkg_pkg;

  // Key guard state, one-hot
  typedef enum logic [1:0] {
    WDKG_KS_OK = 2'b01,
    WDKG_KS_WAIT = 2'b10
  } wdkg_key_state_t;

endpackage : wdkg_pkg

// ---- inc/wdkg_regs.svh ----
// Register map, field positions, reset values and timing counts
`ifndef WDKG_REGS_SVH
`define WDKG_REGS_SVH

// Byte offsets of the APB registers
`define WDKG_CTRL_OFS 8'h00
`define WDKG_CAUSE_OFS 8'h04
`define WDKG_STAT_OFS 8'h08
`define WDKG_IRQ_OFS 8'h0c
`define WDKG_MASK_OFS 8'h10

// Control register layout and reset value
`define WDKG_CTRL_RST 8'h53
`define WDKG_KEY_HI 7
`define WDKG_KEY_LO 3
`define WDKG_SEL_HI 2
`define WDKG_SEL_LO 0

// Key codes
`define WDKG_KEY_A 5'h15
`define WDKG_KEY_B 5'h0a

// Reset cause flags: key reset flag position
`define WDKG_KEYF_BIT 0

// Status register positions
`define WDKG_TO_BIT 0
`define WDKG_PDF_BIT 1

// Interrupt status positions: overflow, invalid key
`define WDKG_IRQ_OVF 0
`define WDKG_IRQ_KEY 1

// Slow oscillator nominal rate and bus clock rate
`define WDKG_SLOW_HZ 32000
`define WDKG_PCLK_MHZ 250

// Software reset delay in ns and derived bus-clock count (rounded up)
`define WDKG_SRESET_NS 1000
`define WDKG_SRESET_CYC ((`WDKG_SRESET_NS * `WDKG_PCLK_MHZ + 999) / 1000)

// Time-out exponents for the eight period codes
`define WDKG_EXP0 8
`define WDKG_EXP1 10
`define WDKG_EXP2 12
`define WDKG_EXP3 14
`define WDKG_EXP4 15
`define WDKG_EXP5 16
`define WDKG_EXP6 17
`define WDKG_EXP7 18

`endif

// ---- tb/wdkg_watchdog_bench.sv ----
// Self-checking bench for the key-guarded watchdog over APB
`timescale 1ns/1ns
`include "wdkg_regs.svh"

module wdkg_watchdog_bench;
  localparam int SRST = 4; // Short key-reset delay for simulation
  logic pclk = 1'b0; // Bus clock, 4 ns period
  logic presetn; // Async reset, active low
  logic psel, penable, pwrite; // APB request
  logic [7:0] paddr; // APB byte address
  logic [31:0] pwdata, prdata; // APB data
  logic pready, pslverr; // APB answer
  logic slow_osc_clk = 1'b0; // Slow tick source
  logic cfg_always_on, clear_watchdog_instruction_instr, halt_instr, halted;
  logic device_reset, pc_sp_reset, irq; // Design outputs
  logic [1:0] div = 2'h0; // Slow clock divider
  logic [31:0] rd_v; // Last read data
  logic er_v, dr_v, ps_v; // Last error, reset pulses seen
  int n_v, e, mismatches = 0, checks = 0;
  logic [4:0] bad [3] = '{5'h00, 5'h1f, 5'h0b}; // Invalid keys

  // Bus clock
  always #2 pclk = ~pclk;

  // Slow oscillator stand-in: one tick every 8 bus cycles
  always @(posedge pclk) begin
    div <= div + 2'h1;
    if (div == 2'h3) begin
      slow_osc_clk <= ~slow_osc_clk;
    end
  end

  wdkg_watchdog #(.SRESET_CYC(SRST)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .slow_osc_clk(slow_osc_clk),
    .cfg_always_on(cfg_always_on), .clear_watchdog_instruction_instr(clear_watchdog_instruction_instr),
    .halt_instr(halt_instr), .halted(halted),
    .device_reset(device_reset), .pc_sp_reset(pc_sp_reset), .irq(irq)
  );

  // Value comparison
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  // Cycle count comparison against a window
  task cmp_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      mismatches++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : cmp_rng

  // One APB transfer; holds the request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the run watchdog ends a hang
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd_v = prdata;
    er_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  // Register read with expected data and error
  task rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    apb(1'b0, a, 32'h0);
    cmp(rd_v, x);
    cmp({31'h0, er_v}, {31'h0, xe});
  endtask : rd_chk

  // One-cycle instruction pulse: halt when h, else clear-watchdog
  task pulse(input logic h);
    @(posedge pclk);
    if (h) begin
      halt_instr <= 1'b1;
    end else begin
      clear_watchdog_instruction_instr <= 1'b1;
    end
    @(posedge pclk);
    halt_instr <= 1'b0;
    clear_watchdog_instruction_instr <= 1'b0;
  endtask : pulse

  // Wait up to lim cycles for either reset pulse
  task wait_ev(input int lim);
    n_v = 0;
    dr_v = 1'b0;
    ps_v = 1'b0;
    while (n_v < lim && dr_v !== 1'b1 && ps_v !== 1'b1) begin
      @(posedge pclk);
      n_v++;
      dr_v = device_reset;
      ps_v = pc_sp_reset;
    end
  endtask : wait_ev

  // Verdict and end of run
  task print_verdict;
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  // Watchdog against a hung run
  initial begin
    repeat (80000) @(posedge pclk);
    mismatches++;
    print_verdict();
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {clear_watchdog_instruction_instr, halt_instr, halted} = 3'h0;
    cfg_always_on = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`WDKG_CTRL_OFS, 32'h53, 1'b0);
    rd_chk(`WDKG_CAUSE_OFS, 32'h0, 1'b0);
    rd_chk(`WDKG_STAT_OFS, 32'h0, 1'b0);
    rd_chk(8'h14, 32'h0, 1'b1);
    wr(`WDKG_MASK_OFS, 32'h3);
    // Overflow timing for the three shortest periods
    for (int c = 0; c < 3; c++) begin
      wr(`WDKG_CTRL_OFS, {`WDKG_KEY_B, c[2:0]});
      pulse(1'b0);
      e = (c == 0) ? `WDKG_EXP0 : (c == 1) ? `WDKG_EXP1 : `WDKG_EXP2;
      wait_ev((2 ** e + 4) * 8);
      cmp(dr_v, 1'b1);
      cmp_rng(n_v, (2 ** e - 1) * 8, (2 ** e + 2) * 8);
    end
    cmp(irq, 1'b1);
    rd_chk(`WDKG_STAT_OFS, 32'h1, 1'b0);
    rd_chk(`WDKG_IRQ_OFS, 32'h1, 1'b0);
    repeat (2) @(posedge pclk);
    cmp(irq, 1'b0);
    // The longer period codes are held as written
    for (int c = 3; c < 8; c++) begin
      wr(`WDKG_CTRL_OFS, {`WDKG_KEY_B, c[2:0]});
      rd_chk(`WDKG_CTRL_OFS, {`WDKG_KEY_B, c[2:0]}, 1'b0);
    end
    // Regular clears keep the overflow away
    wr(`WDKG_CTRL_OFS, 32'h50);
    repeat (3) begin
      pulse(1'b0);
      wait_ev(180 * 8);
      cmp(dr_v | ps_v, 1'b0);
    end
    // Halt, then overflow while halted, with the interrupt masked
    pulse(1'b1);
    rd_chk(`WDKG_STAT_OFS, 32'h2, 1'b0);
    halted <= 1'b1;
    wr(`WDKG_MASK_OFS, 32'h0);
    wait_ev(300 * 8);
    cmp(ps_v, 1'b1);
    cmp(dr_v, 1'b0);
    cmp(irq, 1'b0);
    rd_chk(`WDKG_STAT_OFS, 32'h3, 1'b0);
    wr(`WDKG_MASK_OFS, 32'h1);
    repeat (2) @(posedge pclk);
    cmp(irq, 1'b1);
    halted <= 1'b0;
    pulse(1'b0);
    rd_chk(`WDKG_STAT_OFS, 32'h0, 1'b0);
    // Power-up in mid-run drops power-down and reloads the key
    pulse(1'b1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`WDKG_STAT_OFS, 32'h0, 1'b0);
    rd_chk(`WDKG_CTRL_OFS, 32'h53, 1'b0);
    // Register-controlled option: stop key, then run key
    cfg_always_on <= 1'b0;
    wr(`WDKG_CTRL_OFS, {`WDKG_KEY_A, 3'h0});
    pulse(1'b0);
    wait_ev(300 * 8);
    cmp(dr_v | ps_v, 1'b0);
    wr(`WDKG_CTRL_OFS, 32'h50);
    pulse(1'b0);
    wait_ev(300 * 8);
    cmp(dr_v, 1'b1);
    // Always-on option: the other key keeps it running
    cfg_always_on <= 1'b1;
    wr(`WDKG_CTRL_OFS, {`WDKG_KEY_A, 3'h0});
    pulse(1'b0);
    wait_ev(300 * 8);
    cmp(dr_v, 1'b1);
    // Invalid keys: delayed reset, cause flag, flag clearing
    for (int k = 0; k < 3; k++) begin
      pulse(1'b0);
      apb(1'b0, `WDKG_IRQ_OFS, 32'h0);
      wr(`WDKG_CTRL_OFS, {bad[k], 3'h0});
      wait_ev(20);
      cmp(dr_v, 1'b1);
      cmp_rng(n_v, SRST, SRST + 3);
      rd_chk(`WDKG_CTRL_OFS, 32'h53, 1'b0);
      rd_chk(`WDKG_CAUSE_OFS, 32'h1, 1'b0);
      rd_chk(`WDKG_IRQ_OFS, 32'h2, 1'b0);
      wr(`WDKG_CAUSE_OFS, 32'h1);
      rd_chk(`WDKG_CAUSE_OFS, 32'h1, 1'b0);
      wr(`WDKG_CAUSE_OFS, 32'h0);
      rd_chk(`WDKG_CAUSE_OFS, 32'h0, 1'b0);
    end
    print_verdict();
  end
endmodule : wdkg_watchdog_bench
